// *** rtl/ipr_bank.sv ***
// Bank of six interrupt priority registers with per-source outputs.
// Assumes a plain register port; read data stands one cycle after the
// read strobe. Arbitration, enables and flags sit outside.
`default_nettype none
`include "ipr_params.svh"
// What this block does
// RULE1: Each priority field is three bits; 111 means level 7, the highest.
// RULE2: Field value 001 means level 1, the lowest active level.
// RULE3: Field value 000 disables the source; it never raises a request.
// RULE4: Unassigned bits ignore writes and read back as zero.
// RULE5: Every field resets to 100, level 4.
// RULE6: Register 1: timer2 14-12, outcmp2 10-8, incap2 6-4.
// RULE7: Register 2: uart1 rx 14-12, spi1 event 10-8, fault 6-4, timer3 2-0.
// RULE8: Register 3: adc done 6-4, uart1 tx 2-0.
// RULE9: Register 4: change notify, comparator, i2c1 master, i2c1 slave.
// RULE10: Register 5: incap8 14-12, incap7 10-8, extirq1 2-0.
// RULE11: Register 6: timer4 14-12, outcmp4 10-8, outcmp3 6-4.
// RULE12: Codes 010 to 110 give levels 2 to 6; larger is more urgent.
// RULE13: Writes take effect next edge; reads return stored fields.
module ipr_bank (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [2:0] timer2_prio,
  output logic [2:0] outcmp2_prio,
  output logic [2:0] incap2_prio,
  output logic [2:0] uart1_rx_prio,
  output logic [2:0] spi1_event_prio,
  output logic [2:0] spi1_fault_prio,
  output logic [2:0] timer3_prio,
  output logic [2:0] adc_done_prio,
  output logic [2:0] uart1_tx_prio,
  output logic [2:0] change_notify_prio,
  output logic [2:0] comparator_prio,
  output logic [2:0] i2c1_master_prio,
  output logic [2:0] i2c1_slave_prio,
  output logic [2:0] incap8_prio,
  output logic [2:0] incap7_prio,
  output logic [2:0] extirq1_prio,
  output logic [2:0] timer4_prio,
  output logic [2:0] outcmp4_prio,
  output logic [2:0] outcmp3_prio,
  output logic [18:0] src_enabled
);

  // ========================================================================
  // Register table
  localparam logic [15:0] MASKS [6] = '{`IPR_MASK_CFG_1, `IPR_MASK_CFG_2,
    `IPR_MASK_CFG_3, `IPR_MASK_CFG_4, `IPR_MASK_CFG_5, `IPR_MASK_CFG_6};
  localparam logic [2:0] INDICES [6] = '{`IPR_IDX_CFG_1, `IPR_IDX_CFG_2,
    `IPR_IDX_CFG_3, `IPR_IDX_CFG_4, `IPR_IDX_CFG_5, `IPR_IDX_CFG_6};

  function automatic logic [2:0] field_at(input logic [15:0] word,
                                          input int pos);
    field_at = word[pos +: 3]; // RULE1 RULE12
  endfunction : field_at

  ipr_reg_if rif [6] ();
  ipr_pkg::ipr_word_t val [6];

  // ========================================================================
  // Registers
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_reg
      assign rif[g].wr_en = reg_wr && (reg_addr == INDICES[g]); // RULE13
      assign rif[g].wr_data = reg_wdata;
      assign val[g] = rif[g].value;
      ipr_reg #(.MASK(MASKS[g])) u_reg (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .rif(rif[g])
      );
    end
  endgenerate

  // ========================================================================
  // Read path: unmapped indices read as zero
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic addr_hit;
  assign addr_hit = (reg_addr <= `IPR_IDX_CFG_6);
  assign rdata_d = (reg_rd && addr_hit) ? val[reg_addr] : 16'h0000; // RULE4

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d; // RULE13
  end
  assign reg_rdata = rdata_q;

  // ========================================================================
  // Field map; codes pass through unchanged, so larger means more urgent
  assign timer2_prio = field_at(val[0], `IPR_POS_HI); // RULE6
  assign outcmp2_prio = field_at(val[0], `IPR_POS_MH); // RULE6
  assign incap2_prio = field_at(val[0], `IPR_POS_ML); // RULE6
  assign uart1_rx_prio = field_at(val[1], `IPR_POS_HI); // RULE7
  assign spi1_event_prio = field_at(val[1], `IPR_POS_MH); // RULE7
  assign spi1_fault_prio = field_at(val[1], `IPR_POS_ML); // RULE7
  assign timer3_prio = field_at(val[1], `IPR_POS_LO); // RULE7
  assign adc_done_prio = field_at(val[2], `IPR_POS_ML); // RULE8
  assign uart1_tx_prio = field_at(val[2], `IPR_POS_LO); // RULE8
  assign change_notify_prio = field_at(val[3], `IPR_POS_HI); // RULE9
  assign comparator_prio = field_at(val[3], `IPR_POS_MH); // RULE9
  assign i2c1_master_prio = field_at(val[3], `IPR_POS_ML); // RULE9
  assign i2c1_slave_prio = field_at(val[3], `IPR_POS_LO); // RULE9
  assign incap8_prio = field_at(val[4], `IPR_POS_HI); // RULE10
  assign incap7_prio = field_at(val[4], `IPR_POS_MH); // RULE10
  assign extirq1_prio = field_at(val[4], `IPR_POS_LO); // RULE10
  assign timer4_prio = field_at(val[5], `IPR_POS_HI); // RULE11
  assign outcmp4_prio = field_at(val[5], `IPR_POS_MH); // RULE11
  assign outcmp3_prio = field_at(val[5], `IPR_POS_ML); // RULE11

  // Level 1..7 (RULE2, RULE12) enables; code 000 blocks the source
  logic [2:0] all_prio [19];
  assign all_prio = '{timer2_prio, outcmp2_prio, incap2_prio, uart1_rx_prio,
    spi1_event_prio, spi1_fault_prio, timer3_prio, adc_done_prio,
    uart1_tx_prio, change_notify_prio, comparator_prio, i2c1_master_prio,
    i2c1_slave_prio, incap8_prio, incap7_prio, extirq1_prio, timer4_prio,
    outcmp4_prio, outcmp3_prio};
  generate
    for (g = 0; g < 19; g++)
    begin : g_en
      assign src_enabled[18 - g] = (all_prio[g] != `IPR_FIELD_OFF); // RULE2 RULE3
    end
  endgenerate

endmodule : ipr_bank
`default_nettype wire

// *** common/ipr_params.svh ***
// Offsets, field positions, masks and reset values of the priority bank.
// Assumes a plain register port with 16-bit data and a word index address.
`ifndef IPR_PARAMS_SVH
`define IPR_PARAMS_SVH

// ==========================================================================
// Register indices
`define IPR_IDX_CFG_1 3'h0
`define IPR_IDX_CFG_2 3'h1
`define IPR_IDX_CFG_3 3'h2
`define IPR_IDX_CFG_4 3'h3
`define IPR_IDX_CFG_5 3'h4
`define IPR_IDX_CFG_6 3'h5

// ==========================================================================
// Field positions (low bit of each three-bit field)
`define IPR_POS_HI 12
`define IPR_POS_MH 8
`define IPR_POS_ML 4
`define IPR_POS_LO 0

// ==========================================================================
// Implemented-bit masks per register
`define IPR_MASK_CFG_1 16'h7770
`define IPR_MASK_CFG_2 16'h7777
`define IPR_MASK_CFG_3 16'h0077
`define IPR_MASK_CFG_4 16'h7777
`define IPR_MASK_CFG_5 16'h7707
`define IPR_MASK_CFG_6 16'h7770

// ==========================================================================
// Reset value of every field, and field codes
`define IPR_FIELD_RESET 3'h4
`define IPR_FIELD_OFF 3'h0
`define IPR_REG_RESET 16'h4444

`endif

// *** common/ipr_pkg.sv ***
// Types shared by the priority bank modules.
// Assumes ipr_params.svh is on the include path.
`default_nettype none
package ipr_pkg;
  typedef logic [2:0] ipr_level_t;
  typedef logic [15:0] ipr_word_t;
  typedef logic [2:0] ipr_addr_t;
  localparam int IPR_NREG = 6;
  localparam int IPR_NSRC = 19;
endpackage : ipr_pkg
`default_nettype wire

// *** common/ipr_reg_if.sv ***
// Write path from the bus decoder to one priority register.
// Assumes a single clock domain.
`default_nettype none
interface ipr_reg_if;
  logic wr_en;
  logic [15:0] wr_data;
  logic [15:0] value;
  modport bank (input wr_en, input wr_data, output value);
  modport ctrl (output wr_en, output wr_data, input value);
endinterface : ipr_reg_if
`default_nettype wire

// *** rtl/ipr_reg.sv ***
// One 16-bit priority register with implemented-bit mask.
// Assumes asynchronous active-high reset and a 200 MHz ref_clk.
`default_nettype none
`include "ipr_params.svh"
module ipr_reg #(
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  ipr_reg_if.bank rif
);
  logic [15:0] value_q;
  logic [15:0] value_d;

  // Unimplemented bits never store a written one
  assign value_d = rif.wr_en ? (rif.wr_data & MASK) : value_q; // RULE4

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      value_q <= `IPR_REG_RESET & MASK; // RULE5
    else
      value_q <= value_d; // RULE13
  end

  assign rif.value = value_q;
endmodule : ipr_reg
`default_nettype wire

// *** verif/ipr_bank_assertions.sv ***
// Port-level checks of the priority bank.
// Assumes one clock and the one-cycle read answer of the bank.
`default_nettype none
module ipr_bank_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] timer2_prio,
  input wire logic [2:0] adc_done_prio,
  input wire logic [2:0] uart1_tx_prio,
  input wire logic [2:0] extirq1_prio,
  input wire logic [18:0] src_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Register port
  a_rdata_idle: assert property (!$past(reg_rd) |-> !reg_rdata)
    else $error("read data not zero outside answer");
  a_cfg3_read: assert property ($past(reg_rd) && $past(reg_addr) == 3'h2 |->
    reg_rdata == {9'h000, adc_done_prio, 1'b0, uart1_tx_prio})
    else $error("register 3 read mismatch");
  a_unmapped_read: assert property ($past(reg_rd) && $past(reg_addr) > 3'h5
    |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_timer2_write: assert property (reg_wr && reg_addr == 3'h0 |=>
    timer2_prio == $past(reg_wdata[14:12]))
    else $error("timer2 field not written");
  a_adc_write: assert property (reg_wr && reg_addr == 3'h2 |=>
    adc_done_prio == $past(reg_wdata[6:4]))
    else $error("adc field not written");
  a_extirq_write: assert property (reg_wr && reg_addr == 3'h4 |=>
    extirq1_prio == $past(reg_wdata[2:0]))
    else $error("extirq1 field not written");
  a_timer2_hold: assert property (!(reg_wr && reg_addr == 3'h0) |=>
    $stable(timer2_prio))
    else $error("timer2 field changed without write");
  a_enable_flag: assert property (src_enabled[18] == |timer2_prio &&
    src_enabled[3] == |extirq1_prio)
    else $error("source enable mismatch");
  c_cfg3_read: cover property ($past(reg_rd) && $past(reg_addr) == 3'h2);
  c_top_level: cover property (timer2_prio == 3'h7);
  c_off_level: cover property (extirq1_prio == 3'h0);
endmodule : ipr_bank_assertions
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench driving the priority bank over its register port.
// Assumes ipr_params.svh is on the include path.
`default_nettype none
`include "ipr_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [15:0] m [6];
  logic [18:0] src_enabled;
  wire logic [18:0][2:0] p;
  int err_total = 0, num_checks = 0;
  localparam logic [15:0] MSK [6] = '{`IPR_MASK_CFG_1, `IPR_MASK_CFG_2,
    `IPR_MASK_CFG_3, `IPR_MASK_CFG_4, `IPR_MASK_CFG_5, `IPR_MASK_CFG_6};
  localparam logic [15:0] PAT [5] = '{16'hffff, 16'h0000, 16'h9abc,
    16'h5670, 16'h8ff8};
  ipr_bank uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_enabled(src_enabled), .timer2_prio(p[18]),
    .outcmp2_prio(p[17]), .incap2_prio(p[16]), .uart1_rx_prio(p[15]),
    .spi1_event_prio(p[14]), .spi1_fault_prio(p[13]), .timer3_prio(p[12]),
    .adc_done_prio(p[11]), .uart1_tx_prio(p[10]), .comparator_prio(p[8]),
    .change_notify_prio(p[9]), .i2c1_master_prio(p[7]), .incap8_prio(p[5]),
    .i2c1_slave_prio(p[6]), .incap7_prio(p[4]), .extirq1_prio(p[3]),
    .timer4_prio(p[2]), .outcmp4_prio(p[1]), .outcmp3_prio(p[0]));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [56:0] seen, input logic [56:0] exp);
    num_checks++;
    if (seen !== exp) err_total++;
    if (seen !== exp) $display("ERROR %0t: got %h want %h", $time, seen, exp);
  endtask : chk
  task automatic wr(input int a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a[2:0];
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a < 6) m[a] = d & MSK[a];
  endtask : wr
  task automatic rd(input int a);
    @(posedge ref_clk);
    reg_addr <= a[2:0];
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(57'(reg_rdata), 57'(a < 6 ? m[a] : 16'h0000));
  endtask : rd
  // Expected field outputs in port order, built from the register model
  task automatic outs;
    logic [18:0][2:0] e;
    logic [18:0] en;
    for (int r = 0; r < 6; r++)
      for (int f = 3; f >= 0; f--)
        if (MSK[r][4*f])
        begin
          e = {e[17:0], m[r][4*f +: 3]};
          en = {en[17:0], |m[r][4*f +: 3]};
        end
    chk(p, e);
    chk(57'(src_enabled), 57'(en));
  endtask : outs
  task automatic s_reset;
    for (int r = 0; r < 6; r++) m[r] = `IPR_REG_RESET & MSK[r];
    outs();
    for (int r = 0; r < 6; r++) rd(r);
  endtask : s_reset
  task automatic s_codes;
    for (int v = 0; v < 5; v++)
    begin
      for (int r = 0; r < 6; r++) wr(r, PAT[(v + r) % 5]);
      rd(5);
      outs();
      for (int r = 0; r < 5; r++) rd(r);
    end
  endtask : s_codes
  task automatic s_unmapped;
    wr(6, 16'hffff);
    wr(7, 16'h0000);
    rd(6);
    rd(7);
    outs();
  endtask : s_unmapped
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    s_reset();
    s_codes();
    s_unmapped();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    s_reset();
    tally_and_finish();
  end
endmodule : tb
bind ipr_bank ipr_bank_assertions chk (.*);
`default_nettype wire
